// ===== core/aux_clock_gen.sv
// Auxiliary clock generator: fractional divider from the core clock.
// Assumes the enable arrives already synchronised to mclk_in.
`timescale 1ns/1ps

module aux_clock_gen
	import misc_pins_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	input  wire logic aux_clock_enable_in,
	output logic      aux_clock_out
);
	import misc_pins_pkg::*;

	aux_state_t state_r;
	aux_state_t state_nxt;

	// ------------------------------------------------------------
	// Phase accumulator
	// ------------------------------------------------------------
	// Average rate is exact; edges jitter by one core period since
	// 100 MHz is no integer multiple of 16 MHz.
	always_comb begin
		state_nxt = state_r;
		if (!aux_clock_enable_in) begin
			state_nxt.acc = '0;
			state_nxt.clk = 1'b0;
		end else if (state_r.acc + `AUX_ACC_W'(`AUX_ACC_STEP) >= `AUX_ACC_W'(`AUX_ACC_WRAP)) begin
			state_nxt.acc = state_r.acc + `AUX_ACC_W'(`AUX_ACC_STEP) - `AUX_ACC_W'(`AUX_ACC_WRAP);
			state_nxt.clk = ~state_r.clk;
		end else begin
			state_nxt.acc = state_r.acc + `AUX_ACC_W'(`AUX_ACC_STEP);
		end
	end

	// Register
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign aux_clock_out = state_r.clk;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_aux_off;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!aux_clock_enable_in |=> !aux_clock_out;
	endproperty
	a_aux_off: assert property (p_aux_off) else $error("aux clock runs while disabled");

	property p_aux_toggles;
		@(posedge mclk_in) disable iff (sys_rst_in)
		aux_clock_enable_in [*8] |-> !(aux_clock_out == $past(aux_clock_out)
			&& aux_clock_out == $past(aux_clock_out, 2) && aux_clock_out == $past(aux_clock_out, 3)
			&& aux_clock_out == $past(aux_clock_out, 4));
	endproperty
	a_aux_toggles: assert property (p_aux_toggles) else $error("aux clock stalled");

endmodule // aux_clock_gen

// ===== core/misc_pins.sv
// Miscellaneous control and status pin logic of the slave controller.
// Assumes one core clock; strap, link, system reset, aux enable and serial pins are asynchronous to it.
`timescale 1ns/1ps

module misc_pins
	import misc_pins_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        system_reset_n_in,
	input  wire logic        aux_clock_enable_in,
	output logic             aux_clock_out,
	input  wire logic        reset_request_polarity_in,
	output logic             reset_request_out,
	input  wire logic        master_write_in,
	input  wire logic [15:0] master_write_addr_in,
	input  wire logic        boot_load_done_in,
	output logic             boot_memory_loaded_out,
	input  wire logic        boot_memory_size_strap_in,
	output logic [1:0]       boot_addr_bytes_out,
	input  wire logic        error_in,
	output logic             error_led_out,
	input  wire logic        link_polarity_strap_in,
	input  wire logic        phy_link0_in,
	input  wire logic        phy_link1_in,
	output logic             upstream_link_led_out,
	output logic             downstream_link_led_out,
	input  wire logic        phy_address_offset_in,
	output logic [4:0]       phy_base_addr_out,
	input  wire logic        emulation_strap_in,
	output logic             pdi_owns_state_out,
	input  wire logic        al_request_valid_in,
	input  wire logic [3:0]  al_request_in,
	input  wire logic        pdi_state_write_in,
	input  wire logic [3:0]  pdi_state_data_in,
	output logic [3:0]       al_state_out,
	input  wire logic        shared_bus_strap_in,
	input  wire logic        pdi_sck_in,
	input  wire logic        pdi_mosi_in,
	input  wire logic        pdi_cs_n_in,
	input  wire logic        io_sck_in,
	input  wire logic        io_mosi_in,
	input  wire logic        io_cs_n_in,
	output logic             io_port_sck_out,
	output logic             io_port_mosi_out,
	output logic             io_port_cs_n_out,
	input  wire logic        io_map_enable_in,
	input  wire logic        pd_write_in,
	input  wire logic [7:0]  pd_addr_in,
	input  wire logic [7:0]  pd_data_in,
	output logic             io_reg_write_out,
	output logic [7:0]       io_reg_addr_out,
	output logic [7:0]       io_reg_data_out
);
	import misc_pins_pkg::*;

	// ------------------------------------------------------------
	// Reset image of the state
	// ------------------------------------------------------------
	// Reset request starts inactive for the default polarity 0, so
	// the pin reads high; LEDs start dark, selects idle.
	localparam pins_state_t RESET_STATE = '{
		sync1:      `SYNC_RESET,
		sync2:      `SYNC_RESET,
		cap_cnt:    2'h0,
		rst_pol:    1'b0,
		mem_size:   1'b0,
		link_pol:   1'b0,
		phy_off:    1'b0,
		emul:       1'b0,
		shared:     1'b0,
		rst_req:    1'b0,
		rst_out:    1'b1,
		boot_ok:    1'b0,
		err_led:    1'b1,
		up_led:     1'b0,
		dn_led:     1'b0,
		phy_base:   `PHY_ADDRESS_OFFSET_ZERO,
		addr_bytes: `ADDR_BYTES_SHORT,
		pdi_owns:   1'b1,
		al_state:   `AL_STATE_RESET,
		io_sck:     1'b0,
		io_mosi:    1'b0,
		io_cs_n:    1'b1,
		io_wr:      1'b0,
		io_addr:    8'h00,
		io_data:    8'h00
	};

	pins_state_t state_r;
	pins_state_t state_nxt;

	logic [`SYNC_W-1:0] pins_raw;
	logic               soft_rst;
	logic               capture;

	// Apply a strap-selected polarity to a link indicator
	function automatic logic link_level(input logic raw, input logic active_high);
		link_level = active_high ? raw : ~raw;
	endfunction

	// ------------------------------------------------------------
	// Pin collection
	// ------------------------------------------------------------
	always_comb begin
		pins_raw                  = '0;
		pins_raw[`SY_RST_POL]     = reset_request_polarity_in;
		pins_raw[`SY_MEM_SIZE]    = boot_memory_size_strap_in;
		pins_raw[`SY_LINK_POL]    = link_polarity_strap_in;
		pins_raw[`SY_PHY_OFF]     = phy_address_offset_in;
		pins_raw[`SY_EMUL]        = emulation_strap_in;
		pins_raw[`SY_SHARED]      = shared_bus_strap_in;
		pins_raw[`SY_AUX_EN]      = aux_clock_enable_in;
		pins_raw[`SY_SYS_RST_N]   = system_reset_n_in;
		pins_raw[`SY_LINK0]       = phy_link0_in;
		pins_raw[`SY_LINK1]       = phy_link1_in;
		pins_raw[`SY_PDI_SCK]     = pdi_sck_in;
		pins_raw[`SY_PDI_MOSI]    = pdi_mosi_in;
		pins_raw[`SY_PDI_CS_N]    = pdi_cs_n_in;
		pins_raw[`SY_IO_SCK]      = io_sck_in;
		pins_raw[`SY_IO_MOSI]     = io_mosi_in;
		pins_raw[`SY_IO_CS_N]     = io_cs_n_in;
	end

	// Only the second stage is ever read
	assign soft_rst = ~state_r.sync2[`SY_SYS_RST_N];
	assign capture  = soft_rst || (state_r.cap_cnt != `STRAP_CAPTURE_CYC);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt       = state_r;
		state_nxt.sync1 = pins_raw;
		state_nxt.sync2 = state_r.sync1;

		// Straps follow the pins while in reset, then freeze
		if (state_r.cap_cnt != `STRAP_CAPTURE_CYC) begin
			state_nxt.cap_cnt = state_r.cap_cnt + 2'h1;
		end
		if (capture) begin
			state_nxt.rst_pol  = state_r.sync2[`SY_RST_POL];
			state_nxt.mem_size = state_r.sync2[`SY_MEM_SIZE];
			state_nxt.link_pol = state_r.sync2[`SY_LINK_POL];
			state_nxt.phy_off  = state_r.sync2[`SY_PHY_OFF];
			state_nxt.emul     = state_r.sync2[`SY_EMUL];
			state_nxt.shared   = state_r.sync2[`SY_SHARED];
		end

		// Reset request: set by a master write, cleared by the looped reset
		if (soft_rst) begin
			state_nxt.rst_req  = 1'b0;
			state_nxt.boot_ok  = 1'b0;
			state_nxt.al_state = `AL_STATE_RESET;
		end else begin
			if (master_write_in && master_write_addr_in == `RESET_REG_ADDR) begin
				state_nxt.rst_req = 1'b1;
			end
			if (boot_load_done_in) begin
				state_nxt.boot_ok = 1'b1;
			end
			// Master requests go straight to state only in emulation
			if (state_r.emul && al_request_valid_in) begin
				state_nxt.al_state = al_request_in;
			end else if (!state_r.emul && pdi_state_write_in) begin
				state_nxt.al_state = pdi_state_data_in;
			end
		end
		state_nxt.rst_out = state_r.rst_pol ? state_r.rst_req : ~state_r.rst_req;

		// Protocol and addressing options from the straps
		state_nxt.addr_bytes = state_r.mem_size ? `ADDR_BYTES_LONG : `ADDR_BYTES_SHORT;
		state_nxt.phy_base   = state_r.phy_off ? `PHY_ADDRESS_OFFSET_ONE : `PHY_ADDRESS_OFFSET_ZERO;
		// Process data port keeps access in emulation, but not state control
		state_nxt.pdi_owns   = ~state_r.emul;

		// LEDs
		state_nxt.err_led = ~error_in;
		state_nxt.up_led  = link_level(state_r.sync2[`SY_LINK0], state_r.link_pol);
		state_nxt.dn_led  = link_level(state_r.sync2[`SY_LINK1], state_r.link_pol);

		// I/O block port: own pins, or the process data bus with own select
		if (state_r.shared) begin
			state_nxt.io_sck  = state_r.sync2[`SY_PDI_SCK];
			state_nxt.io_mosi = state_r.sync2[`SY_PDI_MOSI];
		end else begin
			state_nxt.io_sck  = state_r.sync2[`SY_IO_SCK];
			state_nxt.io_mosi = state_r.sync2[`SY_IO_MOSI];
		end
		state_nxt.io_cs_n = state_r.sync2[`SY_IO_CS_N];

		// Process data writes routed to the I/O block when mapped
		state_nxt.io_wr = io_map_enable_in && pd_write_in;
		if (io_map_enable_in && pd_write_in) begin
			state_nxt.io_addr = pd_addr_in;
			state_nxt.io_data = pd_data_in;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Core clock is the reference clock shared with the PHYs
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= RESET_STATE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// Auxiliary clock
	// ------------------------------------------------------------
	aux_clock_gen u_aux (
		.mclk_in             (mclk_in),
		.sys_rst_in          (sys_rst_in),
		.aux_clock_enable_in (state_r.sync2[`SY_AUX_EN]),
		.aux_clock_out       (aux_clock_out)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reset_request_out       = state_r.rst_out;
	assign boot_memory_loaded_out  = state_r.boot_ok;
	assign boot_addr_bytes_out     = state_r.addr_bytes;
	assign error_led_out           = state_r.err_led;
	assign upstream_link_led_out   = state_r.up_led;
	assign downstream_link_led_out = state_r.dn_led;
	assign phy_base_addr_out       = state_r.phy_base;
	assign pdi_owns_state_out      = state_r.pdi_owns;
	assign al_state_out            = state_r.al_state;
	assign io_port_sck_out         = state_r.io_sck;
	assign io_port_mosi_out        = state_r.io_mosi;
	assign io_port_cs_n_out        = state_r.io_cs_n;
	assign io_reg_write_out        = state_r.io_wr;
	assign io_reg_addr_out         = state_r.io_addr;
	assign io_reg_data_out         = state_r.io_data;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_rst_assert;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(master_write_in && master_write_addr_in == `RESET_REG_ADDR && !soft_rst)
			|=> ##1 (reset_request_out == $past(state_r.rst_pol));
	endproperty
	a_rst_assert: assert property (p_rst_assert) else $error("reset request not raised");

	property p_rst_pol;
		@(posedge mclk_in) disable iff (sys_rst_in)
		##1 reset_request_out == ($past(state_r.rst_pol) ~^ $past(state_r.rst_req));
	endproperty
	a_rst_pol: assert property (p_rst_pol) else $error("reset request polarity wrong");

	property p_rst_clear;
		@(posedge mclk_in) disable iff (sys_rst_in)
		soft_rst [*3] |-> reset_request_out == ~$past(state_r.rst_pol);
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("reset request not cleared");

	property p_boot_ok;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(boot_load_done_in && !soft_rst) |=> boot_memory_loaded_out;
	endproperty
	a_boot_ok: assert property (p_boot_ok) else $error("boot status not set");

	property p_boot_clr;
		@(posedge mclk_in) disable iff (sys_rst_in)
		soft_rst |=> !boot_memory_loaded_out;
	endproperty
	a_boot_clr: assert property (p_boot_clr) else $error("boot status kept over reset");

	property p_err_led;
		@(posedge mclk_in) disable iff (sys_rst_in)
		error_in |=> !error_led_out;
	endproperty
	a_err_led: assert property (p_err_led) else $error("error led not lit low");

	property p_link_led;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r.link_pol && state_r.sync2[`SY_LINK0]) |=> upstream_link_led_out;
	endproperty
	a_link_led: assert property (p_link_led) else $error("link led not lit high");

	property p_addr_bytes;
		@(posedge mclk_in) disable iff (sys_rst_in)
		state_r.mem_size [*2] |-> boot_addr_bytes_out == `ADDR_BYTES_LONG;
	endproperty
	a_addr_bytes: assert property (p_addr_bytes) else $error("long address not used");

	property p_phy_zero;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!state_r.phy_off |=> phy_base_addr_out == `PHY_ADDRESS_OFFSET_ZERO;
	endproperty
	a_phy_zero: assert property (p_phy_zero) else $error("phy_address_offset not zero");

	property p_emul_req;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(state_r.emul && al_request_valid_in && !soft_rst) |=> al_state_out == $past(al_request_in);
	endproperty
	a_emul_req: assert property (p_emul_req) else $error("emulated request not applied");

	property p_pdi_owns;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!state_r.emul |=> pdi_owns_state_out;
	endproperty
	a_pdi_owns: assert property (p_pdi_owns) else $error("process data port lost control");

	property p_sep_bus;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!state_r.shared |=> io_port_sck_out == $past(state_r.sync2[`SY_IO_SCK]);
	endproperty
	a_sep_bus: assert property (p_sep_bus) else $error("io port not on own pins");

	property p_straps_hold;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!capture |=> $stable(state_r.emul) && $stable(state_r.rst_pol);
	endproperty
	a_straps_hold: assert property (p_straps_hold) else $error("strap changed outside reset");

endmodule // misc_pins

// ===== core/misc_pins_consts.svh
// Constants for the miscellaneous control and status pin logic.
// Assumes a single 100 MHz core clock; included by bare name.
`ifndef MISC_PINS_CONSTS_SVH
`define MISC_PINS_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CORE_CLK_MHZ        100
`define AUX_CLK_MHZ         16
`define AUX_ACC_W           8
`define AUX_ACC_STEP        (2 * `AUX_CLK_MHZ)
`define AUX_ACC_WRAP        `CORE_CLK_MHZ
`define STRAP_CAPTURE_CYC   2'h3

// ----------------------------------------------------------------
// Positions in the pin synchroniser vector
// ----------------------------------------------------------------
`define SYNC_W              16
`define SY_RST_POL          0
`define SY_MEM_SIZE         1
`define SY_LINK_POL         2
`define SY_PHY_OFF          3
`define SY_EMUL             4
`define SY_SHARED           5
`define SY_AUX_EN           6
`define SY_SYS_RST_N        7
`define SY_LINK0            8
`define SY_LINK1            9
`define SY_PDI_SCK          10
`define SY_PDI_MOSI         11
`define SY_PDI_CS_N         12
`define SY_IO_SCK           13
`define SY_IO_MOSI          14
`define SY_IO_CS_N          15

// ----------------------------------------------------------------
// Addresses and encodings
// ----------------------------------------------------------------
`define RESET_REG_ADDR      16'h0040
`define PHY_ADDRESS_OFFSET_ONE      5'h01
`define PHY_ADDRESS_OFFSET_ZERO     5'h00
`define ADDR_BYTES_SHORT    2'h1
`define ADDR_BYTES_LONG     2'h2
`define AL_STATE_RESET      4'h1
`define SYNC_RESET          16'h9080

`endif

// ===== core/misc_pins_pkg.sv
// Types for the miscellaneous control and status pin logic.
// Assumes misc_pins_consts.svh sits on the include path.
`include "misc_pins_consts.svh"

package misc_pins_pkg;

	// State of the top module, less the auxiliary clock generator
	typedef struct packed {
		logic [`SYNC_W-1:0] sync1;
		logic [`SYNC_W-1:0] sync2;
		logic [1:0]         cap_cnt;
		logic               rst_pol;
		logic               mem_size;
		logic               link_pol;
		logic               phy_off;
		logic               emul;
		logic               shared;
		logic               rst_req;
		logic               rst_out;
		logic               boot_ok;
		logic               err_led;
		logic               up_led;
		logic               dn_led;
		logic [4:0]         phy_base;
		logic [1:0]         addr_bytes;
		logic               pdi_owns;
		logic [3:0]         al_state;
		logic               io_sck;
		logic               io_mosi;
		logic               io_cs_n;
		logic               io_wr;
		logic [7:0]         io_addr;
		logic [7:0]         io_data;
	} pins_state_t;

	// State of the auxiliary clock generator
	typedef struct packed {
		logic [`AUX_ACC_W-1:0] acc;
		logic                  clk;
	} aux_state_t;

endpackage

// ===== verification/board_reset_loop.sv
// Board-side model: loops the reset request pin back into the system reset pin.
// Assumes the request polarity strap is shared with the design instance.
`timescale 1ns/1ps

module board_reset_loop (
	input  wire logic mclk_in,
	input  wire logic reset_request_polarity_in,
	input  wire logic reset_request_in,
	output logic      system_reset_n_out,
	output logic      time_latch_input_0_out,
	output logic      time_latch_input_1_out
);
	// Unused time latch inputs are tied to ground on this board
	assign time_latch_input_0_out = 1'b0;
	assign time_latch_input_1_out = 1'b0;

	// ----------------------------------------------------------------
	// Loopback
	// ----------------------------------------------------------------
	// Pull the system reset low while the request is at its active level;
	// changes land just after the edge, as a board buffer would
	initial system_reset_n_out = 1'b1;
	always @(posedge mclk_in) begin
		system_reset_n_out <= #1 ~(reset_request_in == reset_request_polarity_in);
	end
endmodule // board_reset_loop

// ===== verification/misc_pins_test.sv
// Self-checking bench for the miscellaneous control and status pin logic.
// Assumes the core package and the board reset loop model are compiled first.
`timescale 1ns/1ps

module misc_pins_test;
	import misc_pins_pkg::*;
	logic mclk_in = 0, sys_rst_in = 1, aux_en = 0, pol = 0, mwr = 0, done = 0, size = 0;
	logic err = 0, lpol = 0, lk0 = 0, lk1 = 0, phyoff = 0, emul = 0, alv = 0, pdw = 0;
	logic shared = 0, psck = 0, pmosi = 0, pcs = 1, isck = 0, imosi = 0, ics = 1;
	logic map_en = 0, pd_wr = 0, rst_n, req, aux, loaded, eled, uled, dled, owns;
	logic isck_o, imosi_o, ics_o, io_wr;
	logic [15:0] maddr = 16'h0000;
	logic [3:0]  alreq = 4'h0, pdd = 4'h0, al_st;
	logic [7:0]  pda = 8'h00, pdv = 8'h00, io_a, io_d;
	logic [1:0]  abytes;
	logic [4:0]  phyb;
	int n_errors = 0, samples_checked = 0, seed = 31, k, m, cnt;
	logic [7:0] r;
	logic [3:0] exp_al;

	always #5 mclk_in = ~mclk_in;

	misc_pins u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .system_reset_n_in(rst_n),
		.aux_clock_enable_in(aux_en), .aux_clock_out(aux), .reset_request_polarity_in(pol),
		.reset_request_out(req), .master_write_in(mwr), .master_write_addr_in(maddr),
		.boot_load_done_in(done), .boot_memory_loaded_out(loaded),
		.boot_memory_size_strap_in(size), .boot_addr_bytes_out(abytes), .error_in(err),
		.error_led_out(eled), .link_polarity_strap_in(lpol), .phy_link0_in(lk0),
		.phy_link1_in(lk1), .upstream_link_led_out(uled), .downstream_link_led_out(dled),
		.phy_address_offset_in(phyoff), .phy_base_addr_out(phyb), .emulation_strap_in(emul),
		.pdi_owns_state_out(owns), .al_request_valid_in(alv), .al_request_in(alreq),
		.pdi_state_write_in(pdw), .pdi_state_data_in(pdd), .al_state_out(al_st),
		.shared_bus_strap_in(shared), .pdi_sck_in(psck), .pdi_mosi_in(pmosi),
		.pdi_cs_n_in(pcs), .io_sck_in(isck), .io_mosi_in(imosi), .io_cs_n_in(ics),
		.io_port_sck_out(isck_o), .io_port_mosi_out(imosi_o), .io_port_cs_n_out(ics_o),
		.io_map_enable_in(map_en), .pd_write_in(pd_wr), .pd_addr_in(pda), .pd_data_in(pdv),
		.io_reg_write_out(io_wr), .io_reg_addr_out(io_a), .io_reg_data_out(io_d));

	board_reset_loop u_board (.mclk_in(mclk_in), .reset_request_polarity_in(pol),
		.reset_request_in(req), .system_reset_n_out(rst_n),
		.time_latch_input_0_out(), .time_latch_input_1_out());

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Compare one value, counting every sample
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	// Set every strap to one mode value; straps only matter across a reset
	task automatic straps(input logic v);
		{pol, size, lpol, phyoff, emul, shared} = {6{v}};
	endtask

	task automatic stop_test;
		$display("Counts: %0d checked, %0d errors", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog: the whole run needs a few thousand cycles at most
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Main sequence, once per strap mode
	// ----------------------------------------------------------------
	initial begin
		for (m = 0; m < 2; m++) begin
			tick(1);
			straps(m[0]);
			sys_rst_in = 1;
			tick(10);
			sys_rst_in = 0;
			tick(8);
			chk("req_idle", {15'h0, ~m[0]}, {15'h0, req});
			chk("loaded_rst", 16'h0, {15'h0, loaded});
			chk("addr_bytes", m ? 16'h2 : 16'h1, {14'h0, abytes});
			chk("phy_base", m ? 16'h1 : 16'h0, {11'h0, phyb});
			chk("pdi_owns", {15'h0, ~m[0]}, {15'h0, owns});
			// Straps moved after capture must not leak through; the polarity
			// strap stays, since the board loop wiring follows it
			{size, lpol, phyoff, emul, shared} = {5{~m[0]}};
			tick(6);
			chk("addr_frozen", m ? 16'h2 : 16'h1, {14'h0, abytes});
			chk("phy_frozen", m ? 16'h1 : 16'h0, {11'h0, phyb});
			straps(m[0]);
			$display("Test straps done, mode %0d", m);
			// Error and link LEDs
			err = 1;
			tick(2);
			chk("err_on", 16'h0, {15'h0, eled});
			err = 0;
			tick(2);
			chk("err_off", 16'h1, {15'h0, eled});
			lk0 = m[0];
			lk1 = ~m[0];
			tick(4);
			chk("up_led", 16'h1, {15'h0, uled});
			chk("dn_led", 16'h0, {15'h0, dled});
			$display("Test leds done, mode %0d", m);
			// Aux clock stays low when off, about 16 rising edges per microsecond when on
			aux_en = 0;
			tick(5);
			cnt = 0;
			for (k = 0; k < 100; k++) begin
				tick(1);
				cnt += (aux !== 1'b0);
			end
			chk("aux_off", 16'h0, cnt[15:0]);
			aux_en = 1;
			tick(8);
			cnt = 0;
			for (k = 0; k < 100; k++) begin
				r[0] = aux;
				tick(1);
				cnt += (aux === 1'b1 && r[0] === 1'b0);
			end
			chk("aux_rate", 16'h1, {15'h0, cnt >= 15 && cnt <= 17});
			aux_en = 0;
			$display("Test aux clock done, mode %0d", m);
			// State requests: only the source chosen by the strap is taken
			// Back-to-back requests from both sources; the model keeps the last taken one
			exp_al = 4'h1;
			for (k = 0; k < 4; k++) begin
				r = 8'($random(seed));
				{alv, pdw, alreq, pdd} = {k[0], ~k[0], r[3:0], r[7:4]};
				tick(1);
				if (k[0] == m[0])
					exp_al = m ? r[3:0] : r[7:4];
				chk("al_state", {12'h0, exp_al}, {12'h0, al_st});
			end
			{alv, pdw} = 2'b00;
			$display("Test state requests done, mode %0d", m);
			// Serial port routing by the shared-bus strap
			r = 8'($random(seed));
			{isck, imosi, ics, psck, pmosi} = r[4:0];
			tick(4);
			chk("io_sck", {15'h0, m ? r[1] : r[4]}, {15'h0, isck_o});
			chk("io_mosi", {15'h0, m ? r[0] : r[3]}, {15'h0, imosi_o});
			chk("io_cs", {15'h0, r[2]}, {15'h0, ics_o});
			// Mapped writes pass through, unmapped ones do not
			for (k = 0; k < 2; k++) begin
				r = 8'($random(seed));
				{map_en, pd_wr, pda, pdv} = {k[0], 1'b1, r, ~r};
				tick(1);
				pd_wr = 0;
				chk("io_wr", {15'h0, k[0]}, {15'h0, io_wr});
				if (k == 1)
					chk("io_addr_data", {r, ~r}, {io_a, io_d});
				tick(1);
			end
			$display("Test io port done, mode %0d", m);
			// Master reset register: wrong address ignored, right one loops back
			done = 1;
			tick(1);
			done = 0;
			chk("loaded", 16'h1, {15'h0, loaded});
			{mwr, maddr} = {1'b1, 16'h0041};
			tick(1);
			mwr = 0;
			tick(5);
			chk("req_other", {15'h0, ~m[0]}, {15'h0, req});
			{mwr, maddr} = {1'b1, 16'h0040};
			tick(1);
			mwr = 0;
			for (k = 0; k < 10 && req !== m[0]; k++)
				tick(1);
			chk("req_active", {15'h0, m[0]}, {15'h0, req});
			for (k = 0; k < 20 && req !== ~m[0]; k++)
				tick(1);
			chk("req_cleared", {15'h0, ~m[0]}, {15'h0, req});
			chk("loaded_clr", 16'h0, {15'h0, loaded});
			chk("al_state_clr", 16'h1, {12'h0, al_st});
			$display("Test master reset done, mode %0d", m);
		end
		stop_test();
	end
endmodule // misc_pins_test
